/* File: iocr_consts.svh */
// Offsets, field positions and reset values for the pin and interrupt
// configuration registers. Included by the top-level register block only.
`ifndef IOCR_CONSTS_SVH
`define IOCR_CONSTS_SVH
`define IOCR_ADDR_PIN_MODE   5'h11
`define IOCR_ADDR_IRQ_EN     5'h12
`define IOCR_RST_PIN_MODE    8'h00
`define IOCR_RST_IRQ_EN      8'h00
`define IOCR_BIT_CAN         7
`define IOCR_BIT_HOST_REQ    6
`define IOCR_BIT_LIN2        5
`define IOCR_BIT_LIN1        4
`define IOCR_BIT_PINS        3
`define IOCR_BIT_SAFETY      2
`define IOCR_BIT_UNUSED      1
`define IOCR_BIT_VMON        0
`define IOCR_IRQ_EN_MASK     8'hfd
`endif

/* File: iocr_pkg.sv */
// Types shared by the configuration register block.
// Assumes the consts header is compiled alongside.
package iocr_pkg;
    typedef enum logic [1:0] {
        IOCR_MODE_OFF  = 2'b00,
        IOCR_MODE_WAKE = 2'b01,
        IOCR_MODE_DRV2 = 2'b10,
        IOCR_MODE_DRV3 = 2'b11
    } iocr_mode_e;
    typedef struct packed {
        logic high_side;
        logic low_side;
        logic wake_arm;
    } iocr_pin_ctl_s;
    typedef struct packed {
        logic can_fault;
        logic lin2_fault;
        logic lin1_fault;
        logic pin_fault;
        logic safety;
        logic vmon;
    } iocr_events_s;
endpackage : iocr_pkg

/* File: iocr_pin_decode.sv */
// Decodes one pin's 2-bit mode field into driver and wake-up controls.
// Assumes the field comes straight from the configuration register.
`timescale 1ns/1ps
`default_nettype none
module iocr_pin_decode #(
    parameter bit HAS_LOW_SIDE = 1'b1
) (
    input  wire logic [1:0]              mode,
    output iocr_pkg::iocr_pin_ctl_s      ctl
);
    always_comb begin
        ctl = '0;
        unique case (iocr_pkg::iocr_mode_e'(mode))
            iocr_pkg::IOCR_MODE_OFF: begin
                ctl = '0;
            end
            iocr_pkg::IOCR_MODE_WAKE: begin
                ctl.wake_arm = 1'b1;
            end
            iocr_pkg::IOCR_MODE_DRV2: begin
                // Pins without a low-side switch fall back to high side
                ctl.low_side  = HAS_LOW_SIDE;
                ctl.high_side = !HAS_LOW_SIDE;
            end
            iocr_pkg::IOCR_MODE_DRV3: begin
                ctl.high_side = 1'b1;
            end
        endcase
    end
endmodule : iocr_pin_decode
`default_nettype wire

/* File: iocr_req_pulse.sv */
// Turns a level request into a single one-cycle pulse on its rising edge.
// Assumes the level is synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module iocr_req_pulse (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic level,
    output logic      pulse
);
    logic seen;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            seen <= 1'b0;
        end else begin
            seen <= level;
        end
    end
    // One interrupt per request, not a standing one
    assign pulse = level && !seen;
endmodule : iocr_req_pulse
`default_nettype wire

/* File: iocr_top.sv */
// Pin mode and interrupt enable registers loaded by decoded serial writes.
// Assumes a frame decoder hands over address, data and a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
`include "iocr_consts.svh"
module iocr_top (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 wr_strobe,
    input  wire logic [4:0]           wr_addr,
    input  wire logic [7:0]           wr_data,
    input  wire iocr_pkg::iocr_events_s events,
    output logic [7:0]                pin_mode_config,
    output logic [7:0]                interrupt_source_enable,
    output logic [3:0]                high_side,
    output logic [3:0]                low_side,
    output logic [3:0]                wake_arm,
    output logic                      irq
);
    logic                    host_level;
    logic                    host_pulse;
    logic                    next_irq;
    iocr_pkg::iocr_pin_ctl_s ctl [4];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_mode_config <= `IOCR_RST_PIN_MODE;
        end else if (wr_strobe && wr_addr == `IOCR_ADDR_PIN_MODE) begin
            pin_mode_config <= wr_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            interrupt_source_enable <= `IOCR_RST_IRQ_EN;
        end else if (wr_strobe && wr_addr == `IOCR_ADDR_IRQ_EN) begin
            // Unused bit forced low
            interrupt_source_enable <= wr_data & `IOCR_IRQ_EN_MASK;
        end
    end

    // Pins 3 and 2 only have a high-side switch
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_pin
            iocr_pin_decode #(
                .HAS_LOW_SIDE (i < 2)
            ) u_dec (
                .mode (pin_mode_config[2*i+1 -: 2]),
                .ctl  (ctl[i])
            );
            assign high_side[i] = ctl[i].high_side;
            assign low_side[i]  = ctl[i].low_side;
            assign wake_arm[i]  = ctl[i].wake_arm;
        end
    endgenerate

    assign host_level = interrupt_source_enable[`IOCR_BIT_HOST_REQ]
                     && interrupt_source_enable[`IOCR_BIT_SAFETY];

    iocr_req_pulse u_req (
        .clock (clock),
        .rst   (rst),
        .level (host_level),
        .pulse (host_pulse)
    );

    always_comb begin
        next_irq = host_pulse
            || (events.can_fault
                && interrupt_source_enable[`IOCR_BIT_CAN])
            || (events.lin2_fault
                && interrupt_source_enable[`IOCR_BIT_LIN2])
            || (events.lin1_fault
                && interrupt_source_enable[`IOCR_BIT_LIN1])
            || (events.pin_fault
                && interrupt_source_enable[`IOCR_BIT_PINS])
            || (events.safety
                && interrupt_source_enable[`IOCR_BIT_SAFETY])
            || (events.vmon
                && interrupt_source_enable[`IOCR_BIT_VMON]);
    end

    // Registered so the output never glitches on event edges
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    sequence s_pin_write;
        wr_strobe && wr_addr == `IOCR_ADDR_PIN_MODE;
    endsequence

    sequence s_host_arm;
        !host_level ##1 host_level;
    endsequence

    sequence s_irq_write;
        wr_strobe && wr_addr == `IOCR_ADDR_IRQ_EN;
    endsequence

    sequence s_host_drop;
        host_level ##1 !host_level;
    endsequence

    // Every source idle or masked and no host request pending
    sequence s_all_quiet;
        !host_pulse
        && !(events.can_fault && interrupt_source_enable[`IOCR_BIT_CAN])
        && !(events.lin2_fault && interrupt_source_enable[`IOCR_BIT_LIN2])
        && !(events.lin1_fault && interrupt_source_enable[`IOCR_BIT_LIN1])
        && !(events.pin_fault && interrupt_source_enable[`IOCR_BIT_PINS])
        && !(events.safety && interrupt_source_enable[`IOCR_BIT_SAFETY])
        && !(events.vmon && interrupt_source_enable[`IOCR_BIT_VMON]);
    endsequence

    chk_pin_load: assert property (@(posedge clock) disable iff (rst)
        s_pin_write |=> pin_mode_config == $past(wr_data))
        else $error("pin mode register not loaded");
    chk_irq_load: assert property (@(posedge clock) disable iff (rst)
        wr_strobe && wr_addr == `IOCR_ADDR_IRQ_EN
        |=> interrupt_source_enable[7:2] == $past(wr_data[7:2]))
        else $error("interrupt enable register not loaded");
    chk_unused_zero: assert property (@(posedge clock) disable iff (rst)
        !interrupt_source_enable[`IOCR_BIT_UNUSED])
        else $error("unused enable bit set");
    chk_off_quiet: assert property (@(posedge clock) disable iff (rst)
        pin_mode_config[1:0] == 2'b00 |-> !high_side[0] && !low_side[0]
        && !wake_arm[0])
        else $error("pin 0 active in off mode");
    chk_pin3_hs: assert property (@(posedge clock) disable iff (rst)
        pin_mode_config[7] |-> high_side[3] && !low_side[3])
        else $error("pin 3 high side not enabled");
    chk_pin1_ls: assert property (@(posedge clock) disable iff (rst)
        pin_mode_config[3:2] == 2'b10 |-> low_side[1] && !high_side[1])
        else $error("pin 1 low side not enabled");
    chk_host_once: assert property (@(posedge clock) disable iff (rst)
        s_host_arm ##1 host_level [*3] |-> !host_pulse)
        else $error("host request repeated");
    chk_host_fire: assert property (@(posedge clock) disable iff (rst)
        s_host_arm |=> irq)
        else $error("host request did not interrupt");
    chk_can_gate: assert property (@(posedge clock) disable iff (rst)
        events.can_fault && interrupt_source_enable[`IOCR_BIT_CAN] |=> irq)
        else $error("CAN fault interrupt missing");
    chk_no_source: assert property (@(posedge clock) disable iff (rst)
        s_all_quiet |=> !irq)
        else $error("interrupt without enabled source");

    // Per-pin decode, one field at a time
    chk_off_pin1: assert property (@(posedge clock)
        disable iff (rst) pin_mode_config[3:2] == 2'b00
        |-> !high_side[1] && !low_side[1] && !wake_arm[1])
        else $error("pin 1 active in off mode");

    chk_off_pin2: assert property (@(posedge clock)
        disable iff (rst) pin_mode_config[5:4] == 2'b00
        |-> !high_side[2] && !low_side[2] && !wake_arm[2])
        else $error("pin 2 active in off mode");

    chk_off_pin3: assert property (@(posedge clock)
        disable iff (rst) pin_mode_config[7:6] == 2'b00
        |-> !high_side[3] && !low_side[3] && !wake_arm[3])
        else $error("pin 3 active in off mode");

    chk_pin3_wake: assert property (@(posedge clock)
        disable iff (rst) pin_mode_config[7:6] == 2'b01
        |-> wake_arm[3] && !high_side[3] && !low_side[3])
        else $error("pin 3 wake-up not armed");

    chk_pin3_quiet: assert property (@(posedge clock)
        disable iff (rst) pin_mode_config[7] |-> !wake_arm[3])
        else $error("pin 3 wake-up armed while driving");

    chk_pin2_wake: assert property (@(posedge clock)
        disable iff (rst) pin_mode_config[5:4] == 2'b01
        |-> wake_arm[2] && !high_side[2] && !low_side[2])
        else $error("pin 2 wake-up not armed");

    chk_pin2_hs: assert property (@(posedge clock)
        disable iff (rst) pin_mode_config[5]
        |-> high_side[2] && !low_side[2] && !wake_arm[2])
        else $error("pin 2 high side not enabled");

    chk_pin1_wake: assert property (@(posedge clock)
        disable iff (rst) pin_mode_config[3:2] == 2'b01
        |-> wake_arm[1] && !high_side[1] && !low_side[1])
        else $error("pin 1 wake-up not armed");

    chk_pin1_hs: assert property (@(posedge clock)
        disable iff (rst) pin_mode_config[3:2] == 2'b11
        |-> high_side[1] && !low_side[1] && !wake_arm[1])
        else $error("pin 1 high side not enabled");

    chk_pin0_wake: assert property (@(posedge clock)
        disable iff (rst) pin_mode_config[1:0] == 2'b01
        |-> wake_arm[0] && !high_side[0] && !low_side[0])
        else $error("pin 0 wake-up not armed");

    chk_pin0_ls: assert property (@(posedge clock)
        disable iff (rst) pin_mode_config[1:0] == 2'b10
        |-> low_side[0] && !high_side[0] && !wake_arm[0])
        else $error("pin 0 low side not enabled");

    chk_pin0_hs: assert property (@(posedge clock)
        disable iff (rst) pin_mode_config[1:0] == 2'b11
        |-> high_side[0] && !low_side[0] && !wake_arm[0])
        else $error("pin 0 high side not enabled");

    chk_no_low_upper: assert property (@(posedge clock)
        disable iff (rst) low_side[3:2] == 2'b00)
        else $error("low side driven on pin without low switch");

    chk_one_driver: assert property (@(posedge clock)
        disable iff (rst) (high_side & low_side) == 4'h0)
        else $error("both drivers enabled on one pin");

    chk_wake_no_drive: assert property (@(posedge clock)
        disable iff (rst) (wake_arm & (high_side | low_side)) == 4'h0)
        else $error("wake-up armed on a driving pin");

    // Write path: loads only on a matching strobe
    chk_pin_hold: assert property (@(posedge clock)
        disable iff (rst) !(wr_strobe && wr_addr == `IOCR_ADDR_PIN_MODE)
        |=> $stable(pin_mode_config))
        else $error("pin mode register changed without write");

    chk_irq_hold: assert property (@(posedge clock)
        disable iff (rst) !(wr_strobe && wr_addr == `IOCR_ADDR_IRQ_EN)
        |=> $stable(interrupt_source_enable))
        else $error("interrupt enable register changed without write");

    chk_field_pin3: assert property (@(posedge clock)
        disable iff (rst) s_pin_write ##0 (wr_data[7:6] == 2'b01)
        |=> wake_arm[3])
        else $error("pin 3 field not in bits 7 and 6");

    chk_field_pin0: assert property (@(posedge clock)
        disable iff (rst) s_pin_write ##0 (wr_data[1:0] == 2'b10)
        |=> low_side[0])
        else $error("pin 0 field not in bits 1 and 0");

    chk_irq_mask: assert property (@(posedge clock)
        disable iff (rst) s_irq_write |=> !interrupt_source_enable[1])
        else $error("unused enable bit loaded");

    // Each enabled source reaches the output one cycle later
    chk_lin2_gate: assert property (@(posedge clock)
        disable iff (rst) events.lin2_fault
        && interrupt_source_enable[`IOCR_BIT_LIN2] |=> irq)
        else $error("second LIN fault interrupt missing");

    chk_lin1_gate: assert property (@(posedge clock)
        disable iff (rst) events.lin1_fault
        && interrupt_source_enable[`IOCR_BIT_LIN1] |=> irq)
        else $error("first LIN fault interrupt missing");

    chk_pin_gate: assert property (@(posedge clock)
        disable iff (rst) events.pin_fault
        && interrupt_source_enable[`IOCR_BIT_PINS] |=> irq)
        else $error("pin fault interrupt missing");

    chk_safe_gate: assert property (@(posedge clock)
        disable iff (rst) events.safety
        && interrupt_source_enable[`IOCR_BIT_SAFETY] |=> irq)
        else $error("safety interrupt missing");

    chk_vmon_gate: assert property (@(posedge clock)
        disable iff (rst) events.vmon
        && interrupt_source_enable[`IOCR_BIT_VMON] |=> irq)
        else $error("monitoring interrupt missing");

    // Host request: one pulse per arming
    chk_host_both: assert property (@(posedge clock)
        disable iff (rst) host_pulse
        |-> interrupt_source_enable[6] && interrupt_source_enable[2])
        else $error("host pulse without both enable bits");

    chk_host_edge: assert property (@(posedge clock)
        disable iff (rst) s_host_arm |-> host_pulse)
        else $error("host request not pulsed");

    chk_host_single: assert property (@(posedge clock)
        disable iff (rst) host_pulse |=> !host_pulse)
        else $error("host pulse longer than one cycle");

    chk_host_low: assert property (@(posedge clock)
        disable iff (rst) s_host_drop |-> !host_pulse)
        else $error("host pulse on request removal");

    chk_host_write: assert property (@(posedge clock)
        disable iff (rst) s_irq_write ##0 (wr_data[6] && wr_data[2]
        && !host_level) |=> ##1 irq)
        else $error("host request write did not interrupt");
endmodule : iocr_top
`default_nettype wire

/* File: iocr_host_model.sv */
// Host model: issues decoded register writes.
// Assumes calls come after reset is released.
`timescale 1ns/1ps
`default_nettype none
module iocr_host_model (
    input  wire logic       clock,
    output logic            wr_strobe,
    output logic [4:0]      wr_addr,
    output logic [7:0]      wr_data
);
    initial begin
        wr_strobe = 1'b0;
        wr_addr   = 5'h00;
        wr_data   = 8'h00;
    end
    // Idle bus shows inverted values, never the last write
    task write(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        wr_strobe = 1'b1;
        wr_addr   = a;
        wr_data   = d;
        @(posedge clock);
        #1;
        wr_strobe = 1'b0;
        wr_addr   = ~a;
        wr_data   = ~d;
    endtask : write
endmodule : iocr_host_model
`default_nettype wire

/* File: iocr_top_test.sv */
// Bench for pin mode and interrupt enable registers.
// Assumes the host model drives the write port.
`timescale 1ns/1ps
`default_nettype none
module iocr_top_test;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        wr_strobe, irq;
    logic [4:0]  wr_addr, a;
    logic [7:0]  wr_data, pin_mode_config, interrupt_source_enable, m;
    logic [3:0]  high_side, low_side, wake_arm;
    logic [11:0] e;
    iocr_pkg::iocr_events_s events = '0;
    int          failures = 0;
    int          checked = 0;
    always #10 clock = ~clock;
    iocr_host_model host (.clock(clock), .wr_strobe(wr_strobe),
        .wr_addr(wr_addr), .wr_data(wr_data));
    iocr_top DUT (.clock(clock), .rst(rst), .wr_strobe(wr_strobe),
        .wr_addr(wr_addr), .wr_data(wr_data), .events(events),
        .pin_mode_config(pin_mode_config), .irq(irq),
        .interrupt_source_enable(interrupt_source_enable),
        .high_side(high_side), .low_side(low_side), .wake_arm(wake_arm));
    task chk(input string w, input logic [7:0] x, input logic [7:0] g);
        checked++;
        if (g !== x) begin
            failures++;
            $display("wrong value %s expected %h seen %h", w, x, g);
        end
    endtask : chk
    function automatic logic [11:0] pins(input logic [7:0] v);
        logic [1:0] f;
        logic [11:0] r;
        for (int p = 0; p < 4; p++) begin
            f = v[2*p+:2];
            r[8+p] = f[1] & ((p > 1) | f[0]);
            r[4+p] = (p < 2) && (f == 2'b10);
            r[p]   = (f == 2'b01);
        end
        return r;
    endfunction : pins
    function automatic logic irq_of(input logic [7:0] n,
                                    input iocr_pkg::iocr_events_s v);
        return (n[7] & v.can_fault) | (n[5] & v.lin2_fault)
             | (n[4] & v.lin1_fault) | (n[3] & v.pin_fault)
             | (n[2] & v.safety) | (n[0] & v.vmon);
    endfunction : irq_of
    // Checks irq now and at the following edges, one bit per cycle
    task watch(input logic [3:0] pat);
        for (int k = 0; k < 4; k++) begin
            chk("irq", {7'h00, pat[k]}, {7'h00, irq});
            @(posedge clock);
            #1;
        end
    endtask : watch
    task complete_run;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    initial begin
        #50us;
        failures++;
        complete_run();
    end
    initial begin
        void'($urandom(5));
        repeat (8) @(posedge clock);
        #1 rst = 1'b0;
        chk("pin reset", 8'h00, pin_mode_config);
        chk("irq en reset", 8'h00, interrupt_source_enable);
        $display("reset test done");
        for (int i = 0; i < 40; i++) begin
            m = (i < 4) ? {4{i[1:0]}} : 8'($urandom);
            host.write(5'h11, m);
            e = pins(m);
            chk("pin mode", m, pin_mode_config);
            chk("high side", {4'h0, e[11:8]}, {4'h0, high_side});
            chk("low side", {4'h0, e[7:4]}, {4'h0, low_side});
            chk("wake", {4'h0, e[3:0]}, {4'h0, wake_arm});
            a = 5'($urandom);
            host.write((a == 5'h11 || a == 5'h12) ? 5'h00 : a, ~m);
            chk("pin kept", m, pin_mode_config);
        end
        $display("pin mode test done");
        for (int i = 0; i < 40; i++) begin
            m = (i == 0) ? 8'h02 : 8'($urandom) & 8'hbf;
            host.write(5'h12, m);
            chk("irq en", m & 8'hfd, interrupt_source_enable);
            events = iocr_pkg::iocr_events_s'(6'($urandom));
            @(posedge clock);
            #1;
            chk("irq", {7'h00, irq_of(m, events)}, {7'h00, irq});
        end
        $display("event test done");
        events = '0;
        host.write(5'h12, 8'h40);
        watch(4'b0000);
        host.write(5'h12, 8'h44);
        watch(4'b0010);
        host.write(5'h12, 8'h44);
        watch(4'b0000);
        $display("host request test done");
        complete_run();
    end
endmodule : iocr_top_test
`default_nettype wire
